// >>> src/ppmc_pkg.sv
/*
   ppmc_pkg: constants for the port pin mode configuration block.
   assumes: an APB slave with 32-bit data; one register at a printed offset.
*/
package ppmc_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   // printed offset is not a multiple of four, so it is kept as an index
   localparam logic [7:0]  PPMC_CFG_INDEX  = 8'h9f;
   localparam int          PPMC_ADDR_W     = 12;
   localparam logic [11:0] PPMC_CFG_ADDR   = {2'h0, PPMC_CFG_INDEX, 2'h0};
   localparam logic [7:0]  PPMC_CFG_RESET  = 8'h00;
   localparam int          PPMC_DATA_W     = 32;
   localparam int          PPMC_REG_W      = 8;
   // ---------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------
   localparam int PPMC_MODE_HI   = 7;
   localparam int PPMC_MODE_LO   = 5;
   localparam int PPMC_MODE_W    = 3;
   localparam int PPMC_SEL_BIT   = 4;
   localparam int PPMC_PTR_BIT   = 3;
   localparam int PPMC_IDX_HI    = 2;
   localparam int PPMC_IDX_W     = 3;
   localparam int PPMC_PINS      = 8;
   localparam int PPMC_IN_MODE_W = 2;
   // ---------------------------------------------------------------
   // mode encodings
   // ---------------------------------------------------------------
   localparam logic [2:0] PPMC_OUT_NORMAL = 3'h0;
   localparam logic [2:0] PPMC_OUT_HIGH   = 3'h3;
   localparam logic [1:0] PPMC_IN_NOPULL  = 2'h0;
   localparam logic [1:0] PPMC_IN_PULLDN  = 2'h1;
   localparam logic [1:0] PPMC_IN_OFF     = 2'h2;
   localparam logic       PPMC_SEL_OUT    = 1'b0;
   localparam logic       PPMC_SEL_IN     = 1'b1;
   typedef enum logic [1:0] {
      PPMC_IDLE   = 2'b00,
      PPMC_ACCESS = 2'b01
   } ppmc_phase_t;
endpackage : ppmc_pkg

// >>> src/ppmc_mode_store.sv
/*
   ppmc_mode_store: per-pin input and output mode storage, one write port,
   one registered read port.
   assumes: single clock, synchronous write strobes, clock enable gates all.
*/
`timescale 1ns/10ps
`default_nettype none
module ppmc_mode_store
   import ppmc_pkg::*;
#(
   parameter int PINS = ppmc_pkg::PPMC_PINS
) (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            clk_en,
   input  wire logic                            wr_en,
   input  wire logic                            wr_sel,
   input  wire logic [ppmc_pkg::PPMC_IDX_W-1:0]  wr_idx,
   input  wire logic [ppmc_pkg::PPMC_MODE_W-1:0] wr_mode,
   input  wire logic                            rd_sel,
   input  wire logic [ppmc_pkg::PPMC_IDX_W-1:0]  rd_idx,
   output var  logic [ppmc_pkg::PPMC_MODE_W-1:0] rd_mode,
   output var  logic [PINS*ppmc_pkg::PPMC_MODE_W-1:0] out_mode,
   output var  logic [PINS*ppmc_pkg::PPMC_IN_MODE_W-1:0] in_mode
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PINS-1:0][PPMC_MODE_W-1:0]    outm;
      logic [PINS-1:0][PPMC_IN_MODE_W-1:0] inm;
      logic [PPMC_MODE_W-1:0]              rd;
   } ppmc_store_t;

   ppmc_store_t s_q;
   ppmc_store_t s_d;

   // next state: one pin, one mode kind per write
   always_comb begin
      s_d = s_q;
      if (wr_en) begin
         if (wr_sel == PPMC_SEL_IN) begin
            // input modes only use the low two mode bits
            s_d.inm[wr_idx] = wr_mode[PPMC_IN_MODE_W-1:0];
         end else begin
            s_d.outm[wr_idx] = wr_mode;
         end
      end
      // registered read takes the next pointer and next modes, so it never lags the stored pointer
      if (rd_sel == PPMC_SEL_IN) begin
         s_d.rd = {1'b0, s_d.inm[rd_idx]};
      end else begin
         s_d.rd = s_d.outm[rd_idx];
      end
   end

   // all modes clear on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // fan the stored codes out to the pads
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         assign out_mode[g*PPMC_MODE_W +: PPMC_MODE_W]       = s_q.outm[g];
         assign in_mode[g*PPMC_IN_MODE_W +: PPMC_IN_MODE_W] = s_q.inm[g];
      end
   endgenerate

   assign rd_mode = s_q.rd;
endmodule // ppmc_mode_store
`default_nettype wire

// >>> src/ppmc_top.sv
/*
   ppmc_top: indirectly addressed pin mode configuration register for an
   eight-pin port, reached over APB; drives per-pin controls to the pads.
   assumes: APB master per the protocol, pclk at 250 MHz, pads take the decoded per-pin controls.
*/
// Contract
// - separate input and output mode per pin
// - output codes 000 normal, 011 high
// - input uses bits 6:5, 00 no pull
// - input code 01 adds pull-down
// - input code 10 turns buffer off
// - bit 4 picks output or input
// - bit 3 set stores read pointer
// - pointer write leaves all modes unchanged
// - otherwise mode goes to addressed pin
// - read returns mode at stored pointer
// - bits 2:0 index pin zero to seven
`timescale 1ns/10ps
`default_nettype none
module ppmc_top
   import ppmc_pkg::*;
#(
   parameter int PINS = ppmc_pkg::PPMC_PINS
) (
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire logic                              clk_en,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [ppmc_pkg::PPMC_ADDR_W-1:0]   paddr,
   input  wire logic [ppmc_pkg::PPMC_DATA_W-1:0]   pwdata,
   output var  logic [ppmc_pkg::PPMC_DATA_W-1:0]   prdata,
   output var  logic                              pready,
   output var  logic                              pslverr,
   output var  logic [PINS-1:0]                    drive_high,
   output var  logic [PINS-1:0]                    in_buf_en,
   output var  logic [PINS-1:0]                    pull_down_en,
   output var  logic [PINS-1:0]                    out_code_bad
);
   import ppmc_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      ppmc_phase_t               phase;
      logic                      ptr_sel;
      logic [PPMC_IDX_W-1:0]     ptr_idx;
      logic [PPMC_DATA_W-1:0]    rdata;
      logic                      err;
      logic [PINS-1:0]           hi;
      logic [PINS-1:0]           ibuf;
      logic [PINS-1:0]           pdn;
      logic [PINS-1:0]           bad;
   } ppmc_top_t;

   ppmc_top_t s_q;
   ppmc_top_t s_d;

   logic                          hit;
   logic                          setup;
   logic                          wr_cfg;
   logic                          wr_mode_en;
   logic [PPMC_REG_W-1:0]         wbyte;
   logic [PPMC_MODE_W-1:0]        rd_mode;
   logic [PINS*PPMC_MODE_W-1:0]   out_mode;
   logic [PINS*PPMC_IN_MODE_W-1:0] in_mode;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   // no wait state: setup cycle, then access with pready high, so a
   // transfer with clk_en high at its setup edge takes two cycles and the read is registered
   assign hit        = (paddr == PPMC_CFG_ADDR);
   assign setup      = psel && !penable;
   assign wbyte      = pwdata[PPMC_REG_W-1:0];
   // writes act only at the access edge with pready high, never at setup,
   // so a transfer the master abandons before its answer changes nothing
   assign wr_cfg     = pready && pwrite && hit && clk_en;
   assign wr_mode_en = wr_cfg && !wbyte[PPMC_PTR_BIT];

   // ---------------------------------------------------------------
   // mode storage
   // ---------------------------------------------------------------
   ppmc_mode_store #(
      .PINS (PINS)
   ) u_store (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_en   (clk_en),
      .wr_en    (wr_mode_en),
      .wr_sel   (wbyte[PPMC_SEL_BIT]),
      .wr_idx   (wbyte[PPMC_IDX_HI:0]),
      .wr_mode  (wbyte[PPMC_MODE_HI:PPMC_MODE_LO]),
      .rd_sel   (s_d.ptr_sel),
      .rd_idx   (s_d.ptr_idx),
      .rd_mode  (rd_mode),
      .out_mode (out_mode),
      .in_mode  (in_mode)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // pointer and select captured only by pointer writes
      if (wr_cfg && wbyte[PPMC_PTR_BIT]) begin
         s_d.ptr_sel = wbyte[PPMC_SEL_BIT];
         s_d.ptr_idx = wbyte[PPMC_IDX_HI:0];
      end
      unique case (s_q.phase)
         PPMC_IDLE: begin
            if (setup) begin
               s_d.phase = PPMC_ACCESS;
               s_d.err   = !hit;
            end
         end
         PPMC_ACCESS: begin
            s_d.phase = (psel && !penable) ? PPMC_ACCESS : PPMC_IDLE;
            s_d.err   = setup ? !hit : 1'b0;
         end
         default: begin
            s_d.phase = PPMC_IDLE;
         end
      endcase
      // read data lands in the access cycle; unmapped reads give zero
      s_d.rdata = '0;
      if (setup && !pwrite && hit) begin
         s_d.rdata[PPMC_MODE_HI:PPMC_MODE_LO] = rd_mode;
      end
      // pad controls decoded per pin into flops
      for (int i = 0; i < PINS; i++) begin
         logic [PPMC_MODE_W-1:0]    om;
         logic [PPMC_IN_MODE_W-1:0] im;
         om = out_mode[i*PPMC_MODE_W +: PPMC_MODE_W];
         im = in_mode[i*PPMC_IN_MODE_W +: PPMC_IN_MODE_W];
         s_d.hi[i]   = (om == PPMC_OUT_HIGH);
         // illegal codes fall back to normal drive and are flagged
         s_d.bad[i]  = (om != PPMC_OUT_HIGH) && (om != PPMC_OUT_NORMAL);
         s_d.ibuf[i] = (im != PPMC_IN_OFF);
         s_d.pdn[i]  = (im == PPMC_IN_PULLDN);
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q         <= '0;
         s_q.ibuf    <= '1; // mode 00 means input buffer on
         s_q.phase   <= PPMC_IDLE;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign prdata       = s_q.rdata;
   assign pready       = (s_q.phase == PPMC_ACCESS) && psel && penable;
   assign pslverr      = pready && s_q.err;
   assign drive_high   = s_q.hi;
   assign in_buf_en    = s_q.ibuf;
   assign pull_down_en = s_q.pdn;
   assign out_code_bad = s_q.bad;
endmodule // ppmc_top
`default_nettype wire

// >>> verification/ppmc_asserts.sv
/* ppmc_asserts: bus and pad checks on the ppmc_top ports.
   assumes: bound into every ppmc_top; pads settle within two edges of a store. */
`timescale 1ns/10ps
`default_nettype none
module ppmc_asserts
   import ppmc_pkg::*;
#(parameter int PINS = 8) (
   input wire logic                               pclk,
   input wire logic                               presetn,
   input wire logic                               clk_en,
   input wire logic                               psel,
   input wire logic                               penable,
   input wire logic                               pwrite,
   input wire logic [ppmc_pkg::PPMC_ADDR_W-1:0]   paddr,
   input wire logic [ppmc_pkg::PPMC_DATA_W-1:0]   pwdata,
   input wire logic [ppmc_pkg::PPMC_DATA_W-1:0]   prdata,
   input wire logic                               pready,
   input wire logic                               pslverr,
   input wire logic [PINS-1:0]                    drive_high,
   input wire logic [PINS-1:0]                    in_buf_en,
   input wire logic [PINS-1:0]                    pull_down_en,
   input wire logic [PINS-1:0]                    out_code_bad
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // setup edge of a register write, and the access edge at which it lands
   wire logic su = psel && !penable && pwrite && clk_en && paddr == PPMC_CFG_ADDR;
   wire logic ac = pready && pwrite && clk_en && paddr == PPMC_CFG_ADDR;
   wire logic mw = ac && !pwdata[3];
   // store at the access edge, pad decode at the next edge, checked at the second edge after the access edge
   property p_out;
      logic [2:0] i;
      logic [2:0] m;
      (mw && !pwdata[4], i = pwdata[2:0], m = pwdata[7:5]) |-> ##2
         drive_high[i] == (m == 3'h3) && out_code_bad[i] == (m != 3'h0 && m != 3'h3);
   endproperty
   property p_in;
      logic [2:0] i;
      logic [1:0] c;
      (mw && pwdata[4], i = pwdata[2:0], c = pwdata[6:5]) |-> ##2
         in_buf_en[i] == (c != 2'h2) && pull_down_en[i] == (c == 2'h1);
   endproperty
   ready_one_a: assert property (psel && !penable && clk_en ##1 psel && penable |-> pready)
      else $error("no ready in access cycle");
   ready_idle_a: assert property (!psel |-> !pready)
      else $error("ready while idle");
   err_map_a: assert property (pready |-> pslverr == (paddr != PPMC_CFG_ADDR))
      else $error("slave error wrong for address");
   rd_field_a: assert property (pready && !pwrite |-> prdata[31:8] == '0 && prdata[4:0] == '0)
      else $error("read data outside mode field");
   out_mode_a: assert property (p_out)
      else $error("output pad controls wrong");
   in_mode_a: assert property (p_in)
      else $error("input pad controls wrong");
   ptr_keep_a: assert property (su && pwdata[3] |-> ##2
      ($stable(drive_high) && $stable(in_buf_en) && $stable(pull_down_en))[*2])
      else $error("pointer write changed a pin");
   rst_val_a: assert property ($rose(presetn) |-> in_buf_en == '1 && drive_high == '0
      && pull_down_en == '0)
      else $error("pad controls not at reset value");
   cover property (mw && pwdata[4]);
   cover property (su && pwdata[3]);
   cover property (pready && pslverr);
endmodule // ppmc_asserts
bind ppmc_top ppmc_asserts #(.PINS(PINS)) u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drive_high, .in_buf_en,
   .pull_down_en, .out_code_bad);
`default_nettype wire

// >>> verification/ppmc_pads.sv
/* ppmc_pads: model of the port pad buffers and pull resistors.
   assumes: ext_en marks pins driven from outside the chip. */
`timescale 1ns/10ps
`default_nettype none
module ppmc_pads #(parameter int PINS = 8) (
   input  wire logic            pclk,
   input  wire logic [PINS-1:0] in_buf_en,
   input  wire logic [PINS-1:0] pull_down_en,
   input  wire logic [PINS-1:0] ext_en,
   input  wire logic [PINS-1:0] ext_val,
   output var  logic [PINS-1:0] sensed
);
   logic [PINS-1:0] float_q = '0;
   // an undriven pad with no pull wanders, so it toggles rather than settling
   always_ff @(posedge pclk) begin
      float_q <= ~float_q;
   end
   // buffer off reads low; the pull-down only wins when nothing drives the pad
   always_comb begin
      for (int n = 0; n < PINS; n++) begin
         sensed[n] = !in_buf_en[n] ? 1'b0 :
            ext_en[n] ? ext_val[n] : pull_down_en[n] ? 1'b0 : float_q[n];
      end
   end
endmodule // ppmc_pads
`default_nettype wire

// >>> verification/tb.sv
/* tb: register-level bench for ppmc_top with the pad model beside it.
   assumes: clk_en held high; answers come within twenty cycles. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ppmc_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0]  drive_high, in_buf_en, pull_down_en, out_code_bad, sensed;
   logic [7:0]  ext_en = '0, ext_val = '0;
   int          failures = 0, checks_done = 0;
   always #2 pclk = ~pclk;
   ppmc_top dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .drive_high, .in_buf_en, .pull_down_en, .out_code_bad);
   ppmc_pads pads (.pclk, .in_buf_en, .pull_down_en, .ext_en, .ext_val, .sensed);
   task automatic end_sim();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one transfer; pready, read data and error are taken at the rising edge
   // that ends the access phase, and only then is the request released
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1) begin
         failures++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] d);
      apb(1'b1, PPMC_CFG_ADDR, d);
   endtask
   task automatic rd_mode(input logic s, input logic [2:0] i, input logic [2:0] m);
      wr({24'h0, 3'h7, s, 1'b1, i});
      apb(1'b0, PPMC_CFG_ADDR, '0);
      cmp(rd, {24'h0, m, 5'h0}, "mode read");
   endtask
   // pads follow a store one edge later
   task automatic pads_chk(input logic [31:0] exp);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      cmp({drive_high, in_buf_en, pull_down_en, out_code_bad}, exp, "pads");
   endtask
   task automatic t_rst(input int cyc);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (cyc) @(posedge pclk);
      presetn <= 1'b1;
      pads_chk(32'h00ff0000);
      rd_mode(1'b0, 3'h0, 3'h0);
      rd_mode(1'b1, 3'h7, 3'h0);
   endtask
   task automatic t_out();
      for (int i = 0; i < 8; i++) begin
         wr({24'hffffff, i[0] ? PPMC_OUT_HIGH : PPMC_OUT_NORMAL, 2'b00, i[2:0]});
      end
      for (int i = 0; i < 8; i++) begin
         rd_mode(1'b0, i[2:0], i[0] ? PPMC_OUT_HIGH : PPMC_OUT_NORMAL);
      end
      pads_chk(32'haaff0000);
   endtask
   task automatic t_in();
      logic [1:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 2'(i % 3);
         wr({24'h0, 1'b0, c, 2'b10, i[2:0]});
      end
      for (int i = 0; i < 8; i++) begin
         c = 2'(i % 3);
         rd_mode(1'b1, i[2:0], {1'b0, c});
      end
      pads_chk(32'haadb9200);
      ext_en <= '1;
      ext_val <= '1;
      @(negedge pclk);
      cmp({24'h0, sensed}, 32'hdb, "sensed");
      ext_en <= '0;
      @(negedge pclk);
      cmp({24'h0, sensed & 8'hb6}, 32'h0, "sensed");
   endtask
   task automatic t_bad();
      wr({24'h0, 3'h5, 2'b00, 3'h0}); // broken on purpose
      pads_chk(32'haadb9201);
      wr({24'h0, PPMC_OUT_HIGH, 2'b00, 3'h0});
      pads_chk(32'habdb9200);
   endtask
   task automatic t_unmap();
      apb(1'b1, PPMC_CFG_ADDR + 12'h4, 32'h0);
      cmp({31'h0, err}, 32'h1, "write err");
      apb(1'b0, PPMC_CFG_ADDR - 12'h4, '0);
      cmp(rd, 32'h0, "read data");
      cmp({31'h0, err}, 32'h1, "read err");
      pads_chk(32'habdb9200);
   endtask
   initial begin
      t_rst(6);
      t_out();
      t_in();
      t_bad();
      t_unmap();
      t_rst(2);
      end_sim();
   end
endmodule // tb
`default_nettype wire
